/* File: include/adc_offset_result_mux_regs_defines.vh */
// constants for the converter offset, result and input select registers
`ifndef ADC_OFFSET_RESULT_MUX_REGS_DEFINES_VH
`define ADC_OFFSET_RESULT_MUX_REGS_DEFINES_VH

// ***************************************************
// special-function addresses
// ***************************************************
`define ADDR_OFFSET_CAL_LOW 8'hba
`define ADDR_OFFSET_CAL_MIDDLE 8'hbb
`define ADDR_OFFSET_CAL_HIGH 8'hbe
`define ADDR_INPUT_SELECT 8'hbf
`define ADDR_RESULT_LOW 8'hc3
`define ADDR_RESULT_MIDDLE 8'hc4
`define ADDR_RESULT_HIGH 8'hc5

// ***************************************************
// reset values
// ***************************************************
`define RESET_OFFSET_BYTE 8'h00
`define RESET_RESULT_BYTE 8'h00
`define RESET_INPUT_SELECT 8'h08
`define READ_UNMAPPED 8'h00

// ***************************************************
// input select fields and source codes
// ***************************************************
`define SEL_POS_MSB 7
`define SEL_POS_LSB 4
`define SEL_NEG_MSB 3
`define SEL_NEG_LSB 0
`define SRC_PIN_LAST 4'h7
`define SRC_AGND 4'h8
`define SRC_TEMP_SENSOR 4'h9

`endif

/* File: hw/offset_correct.v */
// subtracts the offset calibration value from each raw filtered result
module offset_correct
#(
   parameter WIDTH = 24
)
(
   input wire clk,
   input wire reset,
   input wire raw_valid,
   input wire [WIDTH-1:0] raw_result,
   input wire [WIDTH-1:0] offset_value,
   output reg corrected_valid,
   output reg [WIDTH-1:0] corrected_result
);

   // one register stage: two's complement difference, wraps modulo 2^WIDTH
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         corrected_valid <= 1'b0;
         corrected_result <= {WIDTH{1'b0}};
      end
      else
      begin
         corrected_valid <= raw_valid;
         if (raw_valid)
         begin
            corrected_result <= raw_result - offset_value;
         end
      end
   end

endmodule // offset_correct

/* File: hw/adc_offset_result_mux_regs.v */
// register side of the converter: offset calibration, result bytes, input select
`include "adc_offset_result_mux_regs_defines.vh"

// Contract
// - offset middle byte at 0xbb holds value bits 15 to 8, read/write, resets to zero.
// - offset low byte at 0xba holds value bits 7 to 0, read/write.
// - the middle offset byte is the middle eight bits of the 24-bit offset value.
// - result high byte at 0xc5 shows result bits 23 to 16, resets to zero.
// - a separate middle result byte shows result bits 15 to 8.
// - result low byte at 0xc3 shows result bits 7 to 0.
// - positive and negative converter inputs are selected independently.
// - each input selects one of eight pins, analog ground or the temperature sensor.
// - one input select register holds both selection fields.
// - the temperature sensor is enabled whenever either input selects it.
// - the offset is a 24-bit two's complement number subtracted from every result.
// - a third offset byte holds the top eight bits of the offset value.
// - software may read and overwrite every offset calibration byte.
module adc_offset_result_mux_regs
#(
   parameter RESULT_WIDTH = 24
)
(
   input wire CLK,
   input wire RESET,
   input wire [7:0] SFR_ADDR,
   input wire SFR_WE,
   input wire SFR_RE,
   input wire [7:0] SFR_WDATA,
   output reg [7:0] SFR_RDATA,
   input wire RAW_VALID,
   input wire [23:0] RAW_RESULT,
   input wire CAL_OFFSET_WE,
   input wire [23:0] CAL_OFFSET,
   output wire [23:0] OFFSET_CAL_VALUE,
   output wire RESULT_UPDATED,
   output reg [3:0] POSITIVE_CONVERTER_INPUT,
   output reg [3:0] NEGATIVE_CONVERTER_INPUT,
   output reg TEMP_SENSOR_EN
);

   // ***************************************************
   // helper functions
   // ***************************************************

   // maps a select field onto a source; reserved codes fall back to ground
   function [3:0] decode_source;
      input [3:0] code;
      begin
         if (code <= `SRC_PIN_LAST)
            decode_source = code;
         else if (code == `SRC_TEMP_SENSOR)
            decode_source = `SRC_TEMP_SENSOR;
         else
            decode_source = `SRC_AGND;
      end
   endfunction

   // ***************************************************
   // storage
   // ***************************************************
   reg [7:0] offset_cal_low_byte_q;
   reg [7:0] offset_cal_middle_byte_q;
   reg [7:0] offset_cal_high_byte_q;
   reg [7:0] conversion_result_low_byte_q;
   reg [7:0] conversion_result_middle_byte_q;
   reg [7:0] conversion_result_high_byte_q;
   reg [7:0] input_select_register_q;
   reg [7:0] rdata_d;
   reg [3:0] pos_src_d;
   reg [3:0] neg_src_d;
   wire corrected_valid;
   wire [23:0] corrected_result;

   // write strobes per register
   wire we_off_low = SFR_WE && (SFR_ADDR == `ADDR_OFFSET_CAL_LOW);
   wire we_off_mid = SFR_WE && (SFR_ADDR == `ADDR_OFFSET_CAL_MIDDLE);
   wire we_off_high = SFR_WE && (SFR_ADDR == `ADDR_OFFSET_CAL_HIGH);
   wire we_res_low = SFR_WE && (SFR_ADDR == `ADDR_RESULT_LOW);
   wire we_res_mid = SFR_WE && (SFR_ADDR == `ADDR_RESULT_MIDDLE);
   wire we_res_high = SFR_WE && (SFR_ADDR == `ADDR_RESULT_HIGH);
   wire we_sel = SFR_WE && (SFR_ADDR == `ADDR_INPUT_SELECT);

   // full offset value assembled from the three bytes
   assign OFFSET_CAL_VALUE = {offset_cal_high_byte_q, offset_cal_middle_byte_q,
      offset_cal_low_byte_q};
   assign RESULT_UPDATED = corrected_valid;

   // ***************************************************
   // offset calibration bytes
   // ***************************************************

   // calibration engine load wins over a software write in the same cycle
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         offset_cal_low_byte_q <= `RESET_OFFSET_BYTE;
         offset_cal_middle_byte_q <= `RESET_OFFSET_BYTE;
         offset_cal_high_byte_q <= `RESET_OFFSET_BYTE;
      end
      else if (CAL_OFFSET_WE)
      begin
         offset_cal_low_byte_q <= CAL_OFFSET[7:0];
         offset_cal_middle_byte_q <= CAL_OFFSET[15:8];
         offset_cal_high_byte_q <= CAL_OFFSET[23:16];
      end
      else
      begin
         if (we_off_low)
            offset_cal_low_byte_q <= SFR_WDATA;
         if (we_off_mid)
            offset_cal_middle_byte_q <= SFR_WDATA;
         if (we_off_high)
            offset_cal_high_byte_q <= SFR_WDATA;
      end
   end

   // ***************************************************
   // offset subtraction
   // ***************************************************
   offset_correct
   #(
      .WIDTH(RESULT_WIDTH)
   )
   u_offset_correct
   (
      .clk(CLK),
      .reset(RESET),
      .raw_valid(RAW_VALID),
      .raw_result(RAW_RESULT),
      .offset_value(OFFSET_CAL_VALUE),
      .corrected_valid(corrected_valid),
      .corrected_result(corrected_result)
   );

   // ***************************************************
   // conversion result bytes
   // ***************************************************

   // a completed sample loads all three bytes at once and beats a software write
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         conversion_result_low_byte_q <= `RESET_RESULT_BYTE;
         conversion_result_middle_byte_q <= `RESET_RESULT_BYTE;
         conversion_result_high_byte_q <= `RESET_RESULT_BYTE;
      end
      else if (corrected_valid)
      begin
         conversion_result_low_byte_q <= corrected_result[7:0];
         conversion_result_middle_byte_q <= corrected_result[15:8];
         conversion_result_high_byte_q <= corrected_result[23:16];
      end
      else
      begin
         if (we_res_low)
            conversion_result_low_byte_q <= SFR_WDATA;
         if (we_res_mid)
            conversion_result_middle_byte_q <= SFR_WDATA;
         if (we_res_high)
            conversion_result_high_byte_q <= SFR_WDATA;
      end
   end

   // ***************************************************
   // input multiplexer control
   // ***************************************************

   // one register carries both selection fields
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         input_select_register_q <= `RESET_INPUT_SELECT;
      else if (we_sel)
         input_select_register_q <= SFR_WDATA;
   end

   // each field decoded on its own
   always @*
   begin
      pos_src_d = decode_source(input_select_register_q[`SEL_POS_MSB:`SEL_POS_LSB]);
      neg_src_d = decode_source(input_select_register_q[`SEL_NEG_MSB:`SEL_NEG_LSB]);
   end

   // registered mux controls and automatic sensor enable
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         POSITIVE_CONVERTER_INPUT <= 4'h0;
         NEGATIVE_CONVERTER_INPUT <= `SRC_AGND;
         TEMP_SENSOR_EN <= 1'b0;
      end
      else
      begin
         POSITIVE_CONVERTER_INPUT <= pos_src_d;
         NEGATIVE_CONVERTER_INPUT <= neg_src_d;
         TEMP_SENSOR_EN <= (pos_src_d == `SRC_TEMP_SENSOR) ||
            (neg_src_d == `SRC_TEMP_SENSOR);
      end
   end

   // ***************************************************
   // read path
   // ***************************************************

   // address decode for reads; unmapped addresses read zero
   always @*
   begin
      case (SFR_ADDR)
         `ADDR_OFFSET_CAL_LOW: rdata_d = offset_cal_low_byte_q;
         `ADDR_OFFSET_CAL_MIDDLE: rdata_d = offset_cal_middle_byte_q;
         `ADDR_OFFSET_CAL_HIGH: rdata_d = offset_cal_high_byte_q;
         `ADDR_INPUT_SELECT: rdata_d = input_select_register_q;
         `ADDR_RESULT_LOW: rdata_d = conversion_result_low_byte_q;
         `ADDR_RESULT_MIDDLE: rdata_d = conversion_result_middle_byte_q;
         `ADDR_RESULT_HIGH: rdata_d = conversion_result_high_byte_q;
         default: rdata_d = `READ_UNMAPPED;
      endcase
   end

   // read data is captured on the read strobe and held until the next read
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         SFR_RDATA <= `READ_UNMAPPED;
      else if (SFR_RE)
         SFR_RDATA <= rdata_d;
   end

endmodule // adc_offset_result_mux_regs

/* File: verif/adc_offset_result_mux_regs_props.sv */
// concurrent checks on the converter register block ports
`include "adc_offset_result_mux_regs_defines.vh"
module adc_offset_result_mux_regs_props
(
   input wire CLK,
   input wire RESET,
   input wire [7:0] SFR_ADDR,
   input wire SFR_WE,
   input wire SFR_RE,
   input wire [7:0] SFR_WDATA,
   input wire [7:0] SFR_RDATA,
   input wire RAW_VALID,
   input wire CAL_OFFSET_WE,
   input wire [23:0] CAL_OFFSET,
   input wire [23:0] OFFSET_CAL_VALUE,
   input wire RESULT_UPDATED,
   input wire [3:0] POSITIVE_CONVERTER_INPUT,
   input wire [3:0] NEGATIVE_CONVERTER_INPUT,
   input wire TEMP_SENSOR_EN
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   // reserved codes act as ground
   function automatic logic [3:0] dec(input logic [3:0] c);
      return (c > `SRC_TEMP_SENSOR) ? `SRC_AGND : c;
   endfunction
   sequence s_sw_wr(a);
      SFR_WE && !CAL_OFFSET_WE && SFR_ADDR == a;
   endsequence
   sequence s_sel_wr;
      SFR_WE && SFR_ADDR == `ADDR_INPUT_SELECT;
   endsequence
   a_offset_mid_wr: assert property (s_sw_wr(`ADDR_OFFSET_CAL_MIDDLE) |=>
      OFFSET_CAL_VALUE[15:8] == $past(SFR_WDATA)) else $error("middle offset write lost");
   a_offset_low_wr: assert property (s_sw_wr(`ADDR_OFFSET_CAL_LOW) |=>
      OFFSET_CAL_VALUE[7:0] == $past(SFR_WDATA)) else $error("low offset write lost");
   a_offset_high_wr: assert property (s_sw_wr(`ADDR_OFFSET_CAL_HIGH) |=>
      OFFSET_CAL_VALUE[23:16] == $past(SFR_WDATA)) else $error("high offset write lost");
   a_cal_load: assert property (CAL_OFFSET_WE |=>
      OFFSET_CAL_VALUE == $past(CAL_OFFSET)) else $error("calibration load lost");
   a_sel_decode: assert property (s_sel_wr |-> ##2
      POSITIVE_CONVERTER_INPUT == dec($past(SFR_WDATA[7:4], 2)) &&
      NEGATIVE_CONVERTER_INPUT == dec($past(SFR_WDATA[3:0], 2))) else $error("bad select");
   a_temp_enable: assert property (TEMP_SENSOR_EN ==
      (POSITIVE_CONVERTER_INPUT == `SRC_TEMP_SENSOR ||
      NEGATIVE_CONVERTER_INPUT == `SRC_TEMP_SENSOR)) else $error("bad sensor enable");
   a_temp_on_select: assert property (s_sel_wr |-> ##2 TEMP_SENSOR_EN ==
      ($past(SFR_WDATA[7:4], 2) == `SRC_TEMP_SENSOR ||
      $past(SFR_WDATA[3:0], 2) == `SRC_TEMP_SENSOR)) else $error("sensor enable not set");
   a_result_pulse: assert property (RESULT_UPDATED == $past(RAW_VALID))
      else $error("result update pulse wrong");
   a_offset_read: assert property (SFR_RE && SFR_ADDR == `ADDR_OFFSET_CAL_MIDDLE |=>
      SFR_RDATA == $past(OFFSET_CAL_VALUE[15:8])) else $error("offset read wrong");
   a_read_hold: assert property (!$past(SFR_RE) |-> $stable(SFR_RDATA))
      else $error("read data moved");
endmodule // adc_offset_result_mux_regs_props

bind adc_offset_result_mux_regs adc_offset_result_mux_regs_props i_props (.*);

/* File: verif/adc_offset_result_mux_regs_tb_top.sv */
// self-checking bench for the converter register block
`include "adc_offset_result_mux_regs_defines.vh"
module adc_offset_result_mux_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, reset = 1'b1, we = 1'b0, re = 1'b0, rv = 1'b0, cwe = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00;
   logic [23:0] raw = 24'h0, cal = 24'h0, off = 24'h0, r;
   wire [7:0] rd;
   wire [23:0] ocv;
   wire upd, ten;
   wire [3:0] pos, neg;
   integer fails = 0, total_checks = 0, seed = 32'h0a97, i;
   always #2.5 clk = ~clk;
   adc_offset_result_mux_regs i_adc_offset_result_mux_regs (.CLK(clk), .RESET(reset),
      .SFR_ADDR(addr), .SFR_WE(we), .SFR_RE(re), .SFR_WDATA(wd), .SFR_RDATA(rd),
      .RAW_VALID(rv), .RAW_RESULT(raw), .CAL_OFFSET_WE(cwe), .CAL_OFFSET(cal),
      .OFFSET_CAL_VALUE(ocv), .RESULT_UPDATED(upd), .POSITIVE_CONVERTER_INPUT(pos),
      .NEGATIVE_CONVERTER_INPUT(neg), .TEMP_SENSOR_EN(ten));
   // expected source for a stored select code
   function logic [3:0] dec(input logic [3:0] c);
      return (c > `SRC_TEMP_SENSOR) ? `SRC_AGND : c;
   endfunction
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask
   // read one register and compare it
   task rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(negedge clk);
      chk(rd, e);
   endtask
   task conv(input logic [23:0] v);
      @(posedge clk);
      raw <= v;
      rv <= 1'b1;
      r = v - off;
      @(posedge clk);
      rv <= 1'b0;
      @(negedge clk);
      chk(upd, 1'b1);
   endtask
   task give_verdict;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      chk({pos, neg, ten}, 9'h010);
      rdc(`ADDR_OFFSET_CAL_MIDDLE, 8'h00);
      rdc(`ADDR_RESULT_HIGH, 8'h00);
      rdc(`ADDR_INPUT_SELECT, `RESET_INPUT_SELECT);
      rdc(8'hbc, `READ_UNMAPPED);
      $display("reset test done");
      for (i = 0; i < 6; i++)
      begin
         off = $random(seed);
         wr(`ADDR_OFFSET_CAL_LOW, off[7:0]);
         wr(`ADDR_OFFSET_CAL_MIDDLE, off[15:8]);
         wr(`ADDR_OFFSET_CAL_HIGH, off[23:16]);
         rdc(`ADDR_OFFSET_CAL_MIDDLE, off[15:8]);
         rdc(`ADDR_OFFSET_CAL_LOW, off[7:0]);
         rdc(`ADDR_OFFSET_CAL_HIGH, off[23:16]);
         chk(ocv, off);
         conv((i == 0) ? 24'h0 : $random(seed));
         rdc(`ADDR_RESULT_HIGH, r[23:16]);
         rdc(`ADDR_RESULT_MIDDLE, r[15:8]);
         rdc(`ADDR_RESULT_LOW, r[7:0]);
      end
      $display("offset and result test done");
      // calibration load against a software write in the same cycle
      @(posedge clk);
      off = $random(seed);
      cal <= off;
      cwe <= 1'b1;
      addr <= `ADDR_OFFSET_CAL_LOW;
      wd <= ~off[7:0];
      we <= 1'b1;
      @(posedge clk);
      cwe <= 1'b0;
      we <= 1'b0;
      raw <= 24'h000001;
      rv <= 1'b1;
      @(negedge clk);
      chk(ocv, off);
      // back-to-back samples, the second one must stand
      @(posedge clk);
      raw <= 24'hfffffe;
      @(posedge clk);
      rv <= 1'b0;
      r = 24'hfffffe - off;
      rdc(`ADDR_RESULT_HIGH, r[23:16]);
      rdc(`ADDR_RESULT_LOW, r[7:0]);
      $display("calibration test done");
      // result bytes are software writable when no sample loads them
      wr(`ADDR_RESULT_MIDDLE, ~r[15:8]);
      rdc(`ADDR_RESULT_MIDDLE, ~r[15:8]);
      for (i = 0; i < 16; i++)
      begin
         wr(`ADDR_INPUT_SELECT, {i[3:0], 4'hf - i[3:0]});
         repeat (2) @(negedge clk);
         chk({pos, neg}, {dec(i[3:0]), dec(4'hf - i[3:0])});
         chk(ten, i == 9 || i == 6);
         rdc(`ADDR_INPUT_SELECT, {i[3:0], 4'hf - i[3:0]});
      end
      $display("select test done");
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rdc(`ADDR_OFFSET_CAL_LOW, 8'h00);
      rdc(`ADDR_RESULT_HIGH, 8'h00);
      $display("second reset test done");
      give_verdict;
   end
endmodule // adc_offset_result_mux_regs_tb_top
